//--- inc/dzf_defines.svh
// Purpose: offsets, field positions, reset values and counts of the zero-flag control block
// Assumes: 16-bit control words, 8-bit register data
// Notes: included by bare name
`ifndef DZF_DEFINES_SVH
`define DZF_DEFINES_SVH

`define DZF_WORD_W 16
`define DZF_DATA_W 8
`define DZF_IDX_W 7
`define DZF_RW_BIT 15
`define DZF_IDX_HI 14
`define DZF_IDX_LO 8
`define DZF_RW_WRITE 1'h0
`define DZF_RW_READ 1'h1

`define DZF_IDX_POLARITY 7'h0A
`define DZF_IDX_OVS 7'h0C

`define DZF_OVER_BIT 7
`define DZF_GEN_OUT_EN_BIT 6
`define DZF_GPO_HI 5
`define DZF_GPO_LO 0
`define DZF_POL_BIT 6

`define DZF_OVS_RESET 8'h00
`define DZF_POL_RESET 8'h00
`define DZF_READ_NONE 8'h00

`define DZF_CHANNELS 8
`define DZF_SAMPLE_W 24
`define DZF_GPO_N 6
`define DZF_ZERO_RUN 1024
`define DZF_RUN_W 11

`endif

//--- inc/dzf_pkg.sv
// Purpose: shared types of the zero-flag control block
// Assumes: nothing
// Notes: numbers live in dzf_defines.svh
package dzf_pkg;

	// modulator oversampling ratio, one-hot
	typedef enum logic [2:0]
	{
		DZF_OSR_32 = 3'h1,
		DZF_OSR_64 = 3'h2,
		DZF_OSR_128 = 3'h4
	} dzf_osr_e;

endpackage

//--- hdl/dzf_word_tick.sv
// Purpose: one-cycle pulse per rising edge of the word-rate clock
// Assumes: word_rate_clock synchronous to core_clk, high and low for a cycle at least
// Notes: pulse lags the edge by one cycle
`timescale 1ns/10ps
`default_nettype none

module dzf_word_tick
	import dzf_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic word_rate_clock,
	output logic word_tick
);

	logic level_r;
	logic tick_r;
	wire rise = word_rate_clock & ~level_r;

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			level_r <= 1'h0;
			tick_r <= 1'h0;
		end
		else
		begin
			level_r <= word_rate_clock;
			tick_r <= rise;
		end
	end

	assign word_tick = tick_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	chk_tick_single_pulse: assert property (word_tick |=> !word_tick)
		else $error("word tick lasted more than one cycle");

endmodule

`default_nettype wire

//--- hdl/dzf_zero_detect.sv
// Purpose: zero-run detector for one channel
// Assumes: sample held stable between word ticks
// Notes: a nonzero sample clears the run in the next cycle, tick or not
`timescale 1ns/10ps
`default_nettype none
`include "dzf_defines.svh"

module dzf_zero_detect
	import dzf_pkg::*;
#(
	parameter int SAMPLE_W = `DZF_SAMPLE_W,
	parameter int ZERO_RUN = `DZF_ZERO_RUN,
	parameter int RUN_W = `DZF_RUN_W
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic word_tick,
	input wire logic [SAMPLE_W-1:0] sample,
	output logic detect
);

	localparam logic [RUN_W-1:0] RUN_LAST = RUN_W'(ZERO_RUN - 1);

	logic [RUN_W-1:0] count_r;
	logic [RUN_W-1:0] count_nxt;
	logic detect_r;
	logic detect_nxt;
	wire nonzero = |sample;
	wire step = word_tick & ~nonzero & ~detect_r;

	always_comb
	begin
		count_nxt = count_r;
		detect_nxt = detect_r;
		if (nonzero)
		begin
			count_nxt = '0;
			detect_nxt = 1'h0;
		end
		else if (step)
		begin
			count_nxt = count_r + RUN_W'(1);
			detect_nxt = (count_r == RUN_LAST);
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			count_r <= '0;
			detect_r <= 1'h0;
		end
		else
		begin
			count_r <= count_nxt;
			detect_r <= detect_nxt;
		end
	end

	assign detect = detect_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	chk_nonzero_clears_run: assert property (nonzero |=> !detect_r && count_r == '0)
		else $error("nonzero sample left the zero run standing");
	chk_run_reaches_detect: assert property (step && count_r == RUN_LAST |=> detect_r)
		else $error("zero run of full length did not raise detect");
	chk_no_early_detect: assert property ($rose(detect_r) |-> $past(count_r) == RUN_LAST)
		else $error("detect rose before the full zero run");

endmodule

`default_nettype wire

//--- hdl/dzf_top.sv
// Purpose: oversampling, general-output and zero-flag control of an eight-channel DAC
// Assumes: control words arrive whole, one per valid pulse; pins are synchronous
// Notes: flag and pin outputs lag the detectors by one cycle
`timescale 1ns/10ps
`default_nettype none
`include "dzf_defines.svh"

module dzf_top
	import dzf_pkg::*;
#(
	parameter int CHANNELS = `DZF_CHANNELS,
	parameter int SAMPLE_W = `DZF_SAMPLE_W,
	parameter int ZERO_RUN = `DZF_ZERO_RUN,
	parameter int GPO_N = `DZF_GPO_N
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic ctrl_word_valid,
	input wire logic [`DZF_WORD_W-1:0] ctrl_word,
	input wire logic sysclk_ratio_low,
	input wire logic word_rate_clock,
	input wire logic [CHANNELS*SAMPLE_W-1:0] sample_data,
	output logic [`DZF_DATA_W-1:0] read_data,
	output logic read_valid,
	output var dzf_osr_e oversample_sel,
	output logic [GPO_N-1:0] shared_pin,
	output logic [CHANNELS-GPO_N-1:0] channel_silence_flag,
	output logic all_channel_silence_flag
);

	// control word fields
	wire word_is_read = ctrl_word[`DZF_RW_BIT];
	wire [`DZF_IDX_W-1:0] register_index_field = ctrl_word[`DZF_IDX_HI:`DZF_IDX_LO];
	wire [`DZF_DATA_W-1:0] word_data = ctrl_word[`DZF_DATA_W-1:0];

	wire wr_req = ctrl_word_valid & (word_is_read == `DZF_RW_WRITE);
	wire rd_req = ctrl_word_valid & (word_is_read == `DZF_RW_READ);
	wire hit_ovs = (register_index_field == `DZF_IDX_OVS);
	wire hit_pol = (register_index_field == `DZF_IDX_POLARITY);
	wire wr_ovs = wr_req & hit_ovs;
	wire wr_pol = wr_req & hit_pol;

	// oversampling/output register and polarity register contents
	logic [`DZF_DATA_W-1:0] ovs_ctrl_r;
	logic [`DZF_DATA_W-1:0] pol_ctrl_r;

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			ovs_ctrl_r <= `DZF_OVS_RESET;
		end
		else if (wr_ovs)
		begin
			ovs_ctrl_r <= word_data;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			pol_ctrl_r <= `DZF_POL_RESET;
		end
		else if (wr_pol)
		begin
			pol_ctrl_r <= word_data;
		end
	end

	wire ovs_over = ovs_ctrl_r[`DZF_OVER_BIT];
	wire general_output_enable = ovs_ctrl_r[`DZF_GEN_OUT_EN_BIT];
	wire [GPO_N-1:0] general_output_value = ovs_ctrl_r[`DZF_GPO_HI:`DZF_GPO_LO];
	wire silence_flag_polarity = pol_ctrl_r[`DZF_POL_BIT];

	// read-back; an unknown index reads as zero
	wire [`DZF_DATA_W-1:0] rd_sel;

	assign rd_sel = hit_ovs ? ovs_ctrl_r :
		hit_pol ? pol_ctrl_r :
		`DZF_READ_NONE;

	logic [`DZF_DATA_W-1:0] read_data_r;
	logic read_valid_r;

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			read_data_r <= `DZF_READ_NONE;
			read_valid_r <= 1'h0;
		end
		else
		begin
			read_valid_r <= rd_req;
			if (rd_req)
			begin
				read_data_r <= rd_sel;
			end
		end
	end

	assign read_data = read_data_r;
	assign read_valid = read_valid_r;

	// oversampling selection
	dzf_osr_e osr_nxt;
	dzf_osr_e osr_r;

	assign osr_nxt = sysclk_ratio_low ?
		(ovs_over ? DZF_OSR_64 : DZF_OSR_32) :
		(ovs_over ? DZF_OSR_128 : DZF_OSR_64);

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			osr_r <= DZF_OSR_64;
		end
		else
		begin
			osr_r <= osr_nxt;
		end
	end

	assign oversample_sel = osr_r;

	// zero detection, one detector per channel
	logic word_tick;
	logic [CHANNELS-1:0] detect_vec;

	dzf_word_tick u_word_tick
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.word_rate_clock(word_rate_clock),
		.word_tick(word_tick)
	);

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++)
		begin : g_chan
			dzf_zero_detect #(
				.SAMPLE_W(SAMPLE_W),
				.ZERO_RUN(ZERO_RUN),
				.RUN_W(`DZF_RUN_W)
			) u_detect
			(
				.core_clk(core_clk),
				.resetn(resetn),
				.word_tick(word_tick),
				.sample(sample_data[ch*SAMPLE_W +: SAMPLE_W]),
				.detect(detect_vec[ch])
			);
		end
	endgenerate

	// flag levels after polarity
	wire [CHANNELS-1:0] flag_level = detect_vec ^ {CHANNELS{silence_flag_polarity}};
	wire all_level = (&detect_vec) ^ silence_flag_polarity;

	// shared pins: flags or written values
	wire [GPO_N-1:0] shared_nxt;

	assign shared_nxt = general_output_enable ?
		general_output_value :
		flag_level[GPO_N-1:0];

	logic [GPO_N-1:0] shared_r;
	logic [CHANNELS-GPO_N-1:0] ded_flag_r;
	logic all_flag_r;

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			shared_r <= '0;
			ded_flag_r <= '0;
			all_flag_r <= 1'h0;
		end
		else
		begin
			shared_r <= shared_nxt;
			ded_flag_r <= flag_level[CHANNELS-1:GPO_N];
			all_flag_r <= all_level;
		end
	end

	assign shared_pin = shared_r;
	assign channel_silence_flag = ded_flag_r;
	assign all_channel_silence_flag = all_flag_r;

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_write_ovs;
		wr_ovs;
	endsequence

	sequence s_read_any;
		rd_req;
	endsequence

	chk_write_lands_reg: assert property (s_write_ovs |=> ovs_ctrl_r == $past(word_data))
		else $error("write word did not land in the oversampling control register");

	chk_read_keeps_reg: assert property (s_read_any |=> read_valid && $stable(ovs_ctrl_r))
		else $error("read word changed a register or gave no answer");

	chk_osr_high_ratio: assert property (!sysclk_ratio_low && ovs_over
		|=> oversample_sel == DZF_OSR_128)
		else $error("high clock ratio with bit set did not give 128x");

	chk_osr_low_ratio: assert property (sysclk_ratio_low && !ovs_over
		|=> oversample_sel == DZF_OSR_32)
		else $error("low clock ratio with bit clear did not give 32x");

	chk_pin_shows_flag: assert property (!general_output_enable && !silence_flag_polarity
		&& detect_vec[0] |=> shared_pin[0])
		else $error("shared pin did not show channel flag");

	chk_pin_shows_value: assert property (general_output_enable
		|=> shared_pin == $past(general_output_value))
		else $error("shared pin did not show written value");

	chk_dedicated_flag: assert property (detect_vec[CHANNELS-1] && !silence_flag_polarity
		|=> channel_silence_flag[CHANNELS-GPO_N-1])
		else $error("channel in zero condition has inactive flag");

	chk_all_flag_and: assert property (!(&detect_vec) && !silence_flag_polarity
		|=> !all_channel_silence_flag)
		else $error("all-channel flag active with a channel not silent");

	chk_flag_polarity: assert property (silence_flag_polarity && (&detect_vec)
		|=> !all_channel_silence_flag)
		else $error("inverted polarity did not drive the flag low");

endmodule

`default_nettype wire

//--- bench/dzf_host_model.sv
// Purpose: host side of the control word port
// Assumes: one whole word per valid pulse
// Notes: the word lines are scrambled while idle
`timescale 1ns/10ps
`default_nettype none

module dzf_host_model
(
	input wire logic core_clk,
	output logic ctrl_word_valid,
	output logic [15:0] ctrl_word,
	input wire logic [7:0] read_data,
	input wire logic read_valid
);
	initial
	begin
		ctrl_word_valid = 1'h0;
		ctrl_word = 16'h0000;
	end

	task automatic xfer(input logic rd, input logic [6:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		begin
			q = 8'hXX;
			@(posedge core_clk);
			ctrl_word_valid <= 1'h1;
			ctrl_word <= {rd, idx, d};
			@(posedge core_clk);
			ctrl_word_valid <= 1'h0;
			ctrl_word <= ~{rd, idx, d};
			n = rd ? 0 : 8;
			while (n < 8)
			begin
				#1;
				if (read_valid === 1'h1)
				begin
					q = read_data;
					n = 8;
				end
				else
				begin
					n++;
					@(posedge core_clk);
				end
			end
		end
	endtask
endmodule

`default_nettype wire

//--- bench/dzf_top_bench.sv
// Purpose: self-checking bench of the zero-flag control block
// Assumes: zero run shortened to 4 word periods
// Notes: word clock and samples driven by the bench
`timescale 1ns/10ps
`default_nettype none

module dzf_top_bench;
	import dzf_pkg::*;
	localparam int RUN = 4;
	logic core_clk = 1'h0;
	logic resetn = 1'h0;
	logic ratio_low = 1'h0;
	logic wrc = 1'h0;
	logic [191:0] samples = 192'h0;
	wire logic valid;
	wire logic [15:0] word;
	wire logic [7:0] rdata;
	wire logic rvalid;
	dzf_osr_e osr;
	wire logic [5:0] pins;
	wire logic [1:0] chf;
	wire logic allf;
	int failures = 0;
	int checked = 0;
	logic [7:0] q;

	always #50 core_clk = ~core_clk;

	dzf_host_model i_host (.core_clk(core_clk), .ctrl_word_valid(valid), .ctrl_word(word),
		.read_data(rdata), .read_valid(rvalid));

	dzf_top #(.ZERO_RUN(RUN)) i_dut (.core_clk(core_clk), .resetn(resetn),
		.ctrl_word_valid(valid), .ctrl_word(word), .sysclk_ratio_low(ratio_low),
		.word_rate_clock(wrc), .sample_data(samples), .read_data(rdata),
		.read_valid(rvalid), .oversample_sel(osr), .shared_pin(pins),
		.channel_silence_flag(chf), .all_channel_silence_flag(allf));

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
		i_host.xfer(1'h1, idx, 8'h00, q);
		chk("read_data", exp, q);
	endtask

	task automatic wr(input logic [6:0] idx, input logic [7:0] d);
		i_host.xfer(1'h0, idx, d, q);
		repeat (3) @(posedge core_clk);
		#1;
	endtask

	task automatic edges(input int n);
		repeat (n)
		begin
			@(posedge core_clk) wrc <= 1'h1;
			@(posedge core_clk) wrc <= 1'h0;
		end
		repeat (4) @(posedge core_clk);
		#1;
	endtask

	task automatic flags(input logic [5:0] p, input logic [1:0] c, input logic a);
		chk("shared_pin", {2'h0, p}, {2'h0, pins});
		chk("channel_flag", {6'h0, c}, {6'h0, chf});
		chk("all_flag", {7'h0, a}, {7'h0, allf});
	endtask

	task automatic close_out();
		if (failures == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge core_clk);
		resetn <= 1'h1;
		#1;
		chk("osr", 8'h02, {5'h0, osr});
		rd(7'h0C, 8'h00);
		rd(7'h0A, 8'h00);
		wr(7'h0B, 8'hFF);
		rd(7'h0B, 8'h00);
		for (int r = 0; r < 2; r++)
			for (int o = 0; o < 2; o++)
			begin
				@(posedge core_clk) ratio_low <= r[0];
				wr(7'h0C, {o[0], 7'h00});
				chk("osr", r ? (o ? 8'h02 : 8'h01) : (o ? 8'h04 : 8'h02), {5'h0, osr});
			end
		wr(7'h0C, 8'h00);
		edges(RUN - 1);
		flags(6'h00, 2'h0, 1'h0);
		edges(1);
		flags(6'h3F, 2'h3, 1'h1);
		@(posedge core_clk) samples[6*24 +: 24] <= 24'h000001;
		repeat (3) @(posedge core_clk);
		#1;
		flags(6'h3F, 2'h2, 1'h0);
		@(posedge core_clk) samples[6*24 +: 24] <= 24'h000000;
		edges(RUN);
		flags(6'h3F, 2'h3, 1'h1);
		wr(7'h0A, 8'h40);
		flags(6'h00, 2'h0, 1'h0);
		rd(7'h0A, 8'h40);
		@(posedge core_clk) samples[0 +: 24] <= 24'h800000;
		repeat (3) @(posedge core_clk);
		#1;
		flags(6'h01, 2'h0, 1'h1);
		wr(7'h0C, 8'h55);
		chk("shared_pin", 8'h15, {2'h0, pins});
		rd(7'h0C, 8'h55);
		wr(7'h0C, 8'h15);
		flags(6'h01, 2'h0, 1'h1);
		close_out();
	end

	initial
	begin
		#5000000;
		failures++;
		close_out();
	end
endmodule

`default_nettype wire
